// ===== hw/asramc_defines.svh
// Timing figures and derived cycle counts for the asynchronous SRAM host controller
`ifndef ASRAMC_DEFINES_SVH
`define ASRAMC_DEFINES_SVH

`define ASRAMC_CLK_NS 20
`define ASRAMC_ADDR_W 17
`define ASRAMC_DATA_W 8
`define ASRAMC_CNT_W 8

// Least times, nanoseconds, faster grade then slower grade
`define ASRAMC_TAA_F_NS 15
`define ASRAMC_TAA_S_NS 20
`define ASRAMC_TOE_F_NS 7
`define ASRAMC_TOE_S_NS 8
`define ASRAMC_TWP_F_NS 12
`define ASRAMC_TWP_S_NS 15
`define ASRAMC_TCW_F_NS 12
`define ASRAMC_TCW_S_NS 15
`define ASRAMC_TDW_F_NS 8
`define ASRAMC_TDW_S_NS 9
`define ASRAMC_TWHZ_F_NS 5
`define ASRAMC_TWHZ_S_NS 8

// Least time rounded up to whole cycles
`define ASRAMC_CYC_UP(t) (((t) + `ASRAMC_CLK_NS - 1) / `ASRAMC_CLK_NS)
`define ASRAMC_MAX(a, b) (((a) > (b)) ? (a) : (b))

`endif

// ===== hw/asramc_pkg.sv
// Types shared by the asynchronous SRAM host controller
package asramc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WSET = 5'h02,
    ST_WPUL = 5'h04,
    ST_RDWT = 5'h08,
    ST_RCOV = 5'h10
  } asramc_state_t;

  typedef struct packed {
    asramc_state_t state;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic wdone;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [7:0] pul_cnt;
  } asramc_ctrl_t;

  typedef struct packed {
    logic [7:0] cnt;
  } asramc_tmr_t;

endpackage : asramc_pkg

// ===== hw/asramc_tmr_if.sv
// Carrier between the controller and its phase timer
`timescale 1ns/1ps
`default_nettype none
interface asramc_tmr_if;
  logic load;
  logic [7:0] load_val;
  logic done;
  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface : asramc_tmr_if
`default_nettype wire

// ===== hw/asramc_timer.sv
// Down counter that times the read wait and write strobe phases of an SRAM access
`timescale 1ns/1ps
`default_nettype none
module asramc_timer (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  asramc_tmr_if.tmr tif // Load and done
);
  asramc_pkg::asramc_tmr_t st_q;
  asramc_pkg::asramc_tmr_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (tif.load)
    begin
      st_d.cnt = tif.load_val;
    end
    else if (st_q.cnt != 8'h00)
    begin
      st_d.cnt = st_q.cnt - 8'h01;
    end
  end

  // Done is only meaningful in the cycles after a load
  assign tif.done = (st_q.cnt == 8'h00) && !tif.load;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule : asramc_timer
`default_nettype wire

// ===== hw/asramc_ctrl.sv
// Host controller that runs single byte reads and writes on a 128K x 8 asynchronous SRAM
// What this block does
// - Hold select low at least 12 ns fast grade, 15 ns slow grade.
// - With output enable low, strobe lasts strobe-to-float plus data setup.
// - Never drive the data bus while the memory drives read data.
// - Hold the write strobe low at least 12 ns or 15 ns.
// - Present write data 8 ns or 9 ns before end of write.
// - Make the address valid no later than the falling select.
`timescale 1ns/1ps
`default_nettype none
`include "asramc_defines.svh"
module asramc_ctrl #(
  parameter bit FAST_GRADE = 1'b0, // 1: faster grade timing, 0: slower grade
  parameter bit WR_OE_LOW = 1'b0 // 1: keep output enable low during writes
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic req_valid, // Access request
  output logic req_ready, // Controller idle, request taken
  input wire logic req_write, // 1 write, 0 read
  input wire logic [16:0] req_addr, // Byte address
  input wire logic [7:0] req_wdata, // Write byte
  output logic rsp_valid, // Read byte ready, one-cycle pulse
  output logic [7:0] rsp_rdata, // Read byte
  output logic wr_done, // Write finished, one-cycle pulse
  output logic [16:0] sram_addr, // Memory address pins
  output logic sram_cs_n, // Memory select, active low
  output logic sram_oe_n, // Memory output enable, active low
  output logic sram_we_n, // Memory write strobe, active low
  output logic [7:0] sram_dq_o, // Data pins, driven value
  output logic sram_dq_oe, // Data pins, high while the host drives
  input wire logic [7:0] sram_dq_i // Data pins, sampled value
);
  // Default slow grade counts also meet the faster part
  localparam int TAA_NS = FAST_GRADE ? `ASRAMC_TAA_F_NS : `ASRAMC_TAA_S_NS;
  localparam int TOE_NS = FAST_GRADE ? `ASRAMC_TOE_F_NS : `ASRAMC_TOE_S_NS;
  localparam int TWP_NS = FAST_GRADE ? `ASRAMC_TWP_F_NS : `ASRAMC_TWP_S_NS;
  localparam int TCW_NS = FAST_GRADE ? `ASRAMC_TCW_F_NS : `ASRAMC_TCW_S_NS;
  localparam int TDW_NS = FAST_GRADE ? `ASRAMC_TDW_F_NS : `ASRAMC_TDW_S_NS;
  localparam int TWHZ_NS = FAST_GRADE ? `ASRAMC_TWHZ_F_NS : `ASRAMC_TWHZ_S_NS;

  // Read wait covers both address access and output enable access
  localparam int RD_CYC = `ASRAMC_MAX(`ASRAMC_CYC_UP(TAA_NS), `ASRAMC_CYC_UP(TOE_NS));
  // Strobe width; with enable low the memory drivers must first turn off
  localparam int WP_PLAIN = `ASRAMC_MAX(`ASRAMC_CYC_UP(TWP_NS), `ASRAMC_CYC_UP(TDW_NS));
  localparam int WP_OE = `ASRAMC_CYC_UP(TWHZ_NS) + `ASRAMC_CYC_UP(TDW_NS);
  localparam int WP_CYC = WR_OE_LOW ? `ASRAMC_MAX(WP_PLAIN, WP_OE) : WP_PLAIN;
  // Select is low for the set-up cycle plus the strobe
  localparam int CW_CYC = `ASRAMC_MAX(WP_CYC, `ASRAMC_CYC_UP(TCW_NS) - 1);
  localparam int DRV_DLY = WR_OE_LOW ? `ASRAMC_CYC_UP(TWHZ_NS) : 0;

  // A phase of N cycles loads N-1: done shows once the count has reached zero
  localparam logic [7:0] RD_LOAD = 8'(RD_CYC - 1);
  localparam logic [7:0] WP_LOAD = 8'(CW_CYC - 1);
  // Count seen one cycle before the drive starts DRV_DLY cycles into the strobe; the data keeps the rest for set-up
  localparam logic [7:0] DRV_AT = 8'(CW_CYC - DRV_DLY);

  asramc_pkg::asramc_ctrl_t st_q;
  asramc_pkg::asramc_ctrl_t st_d;
  logic [7:0] cnt_left;

  asramc_tmr_if tif ();

  asramc_timer u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tif (tif)
  );

  // Mirror of the phase count, so the data drive can start part way in
  assign cnt_left = st_q.pul_cnt;

  always_comb
  begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.wdone = 1'b0;
    tif.load = 1'b0;
    tif.load_val = 8'h00;
    st_d.pul_cnt = (st_q.pul_cnt != 8'h00) ? st_q.pul_cnt - 8'h01 : 8'h00;
    case (st_q.state)
      asramc_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          st_d.addr = req_addr;
          st_d.cs_n = 1'b0;
          if (req_write)
          begin
            st_d.wdata = req_wdata;
            st_d.oe_n = !WR_OE_LOW;
            // Without WR_OE_LOW output enable is high here, so the memory floats and the host may drive
            st_d.dq_oe = !WR_OE_LOW;
            st_d.state = asramc_pkg::ST_WSET;
          end
          else
          begin
            st_d.oe_n = 1'b0;
            tif.load = 1'b1;
            tif.load_val = RD_LOAD;
            st_d.state = asramc_pkg::ST_RDWT;
          end
        end
        else
        begin
          // Re-park the pins on every idle cycle without a request so no stray level outlives an access
          st_d.cs_n = 1'b1;
          st_d.oe_n = 1'b1;
          st_d.we_n = 1'b1;
          st_d.dq_oe = 1'b0;
        end
      end
      asramc_pkg::ST_WSET:
      begin
        // Select already low before the strobe falls
        // Address has settled a whole cycle, which covers the zero set-up time
        st_d.we_n = 1'b0;
        tif.load = 1'b1;
        tif.load_val = WP_LOAD;
        st_d.pul_cnt = WP_LOAD;
        st_d.state = asramc_pkg::ST_WPUL;
      end
      asramc_pkg::ST_WPUL:
      begin
        // With enable low, wait out the memory's turn-off before driving
        if (!st_q.dq_oe && (cnt_left <= DRV_AT))
        begin
          st_d.dq_oe = 1'b1;
        end
        if (tif.done)
        begin
          // Strobe and select rise together; address and data stay put
          st_d.we_n = 1'b1;
          st_d.cs_n = 1'b1;
          st_d.oe_n = 1'b1;
          st_d.wdone = 1'b1;
          st_d.state = asramc_pkg::ST_RCOV;
        end
      end
      asramc_pkg::ST_RDWT:
      begin
        if (tif.done)
        begin
          // Take the byte while select is still low; the memory floats it soon after
          st_d.rdata = sram_dq_i;
          st_d.rvalid = 1'b1;
          st_d.cs_n = 1'b1;
          st_d.oe_n = 1'b1;
          st_d.state = asramc_pkg::ST_RCOV;
        end
      end
      asramc_pkg::ST_RCOV:
      begin
        // One idle cycle lets the memory drivers float before the next access
        st_d.dq_oe = 1'b0;
        st_d.cs_n = 1'b1;
        st_d.oe_n = 1'b1;
        st_d.we_n = 1'b1;
        st_d.state = asramc_pkg::ST_IDLE;
      end
      default:
      begin
        // An illegal state code falls back to idle with the memory parked
        st_d.state = asramc_pkg::ST_IDLE;
        st_d.cs_n = 1'b1;
        st_d.oe_n = 1'b1;
        st_d.we_n = 1'b1;
        st_d.dq_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q.state <= asramc_pkg::ST_IDLE;
      st_q.addr <= 17'h00000;
      st_q.wdata <= 8'h00;
      st_q.rdata <= 8'h00;
      st_q.rvalid <= 1'b0;
      st_q.wdone <= 1'b0;
      st_q.cs_n <= 1'b1;
      st_q.oe_n <= 1'b1;
      st_q.we_n <= 1'b1;
      st_q.dq_oe <= 1'b0;
      st_q.pul_cnt <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // No clock or refresh pin exists toward the memory
  // Every pin comes straight from a flop, so strobes cannot glitch between states
  assign req_ready = (st_q.state == asramc_pkg::ST_IDLE);
  // Pulses last one cycle; the read byte stays until the next read
  assign rsp_valid = st_q.rvalid;
  assign rsp_rdata = st_q.rdata;
  assign wr_done = st_q.wdone;
  assign sram_addr = st_q.addr;
  assign sram_cs_n = st_q.cs_n;
  assign sram_oe_n = st_q.oe_n;
  assign sram_we_n = st_q.we_n;
  assign sram_dq_o = st_q.wdata;
  assign sram_dq_oe = st_q.dq_oe;

endmodule : asramc_ctrl
`default_nettype wire

// ===== sim/asramc_mem_model.sv
// Behavioural 128K x 8 asynchronous static memory facing the host controller
`timescale 1ns/1ps
`default_nettype none
module asramc_mem_model #(
  parameter int T_ACC = 15 // Access delay in ns
) (
  input wire logic [16:0] addr, // Address pins
  input wire logic cs_n, // Select, active low
  input wire logic oe_n, // Output enable, active low
  input wire logic we_n, // Write strobe, active low
  input wire logic [7:0] dq_in, // Bus level seen by the memory
  output logic [7:0] dq_out // Memory drive, or float pattern
);
  logic [7:0] mem [0:131071];
  logic [7:0] rd;
  wire logic drv;
  wire logic wr_end;
  initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5A;
  assign #(T_ACC) rd = mem[addr];
  assign drv = !cs_n && !oe_n && we_n;
  // A floating bus shows the inverse so a stale byte never passes for read data
  assign dq_out = drv ? rd : ~rd;
  assign wr_end = cs_n | we_n;
  always @(posedge wr_end) mem[addr] <= dq_in;
endmodule : asramc_mem_model
`default_nettype wire

// ===== sim/asramc_ctrl_assertions.sv
// Pin timing checks for the asynchronous SRAM host controller
`timescale 1ns/1ps
`default_nettype none
module asramc_ctrl_assertions #(
  parameter bit WR_OE_LOW = 1'b0 // 1: controller keeps output enable low during writes
) (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic req_valid, // Request
  input wire logic req_ready, // Idle
  input wire logic req_write, // Write
  input wire logic [16:0] req_addr, // Address
  input wire logic [7:0] req_wdata, // Write byte
  input wire logic rsp_valid, // Read done
  input wire logic [7:0] rsp_rdata, // Read byte
  input wire logic wr_done, // Write done
  input wire logic [16:0] sram_addr, // Address pins
  input wire logic sram_cs_n, // Select
  input wire logic sram_oe_n, // Output enable
  input wire logic sram_we_n, // Strobe
  input wire logic [7:0] sram_dq_o, // Host drive
  input wire logic sram_dq_oe, // Host enable
  input wire logic [7:0] sram_dq_i // Bus level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Strobe lasts one cycle, or two when the memory must first release the bus
  localparam int WR_LAT = WR_OE_LOW ? 4 : 3;
  a_read_resp_time: assert property (req_valid && req_ready && !req_write |-> ##2 rsp_valid)
    else $error("read answer late");
  a_write_done_time: assert property (req_valid && req_ready && req_write |-> ##WR_LAT wr_done)
    else $error("write done late");
  a_oe_write_seq: assert property (WR_OE_LOW && req_valid && req_ready && req_write |=>
    (!sram_cs_n && !sram_oe_n && sram_we_n && !sram_dq_oe) ##1 (!sram_we_n && !sram_dq_oe)
    ##1 (!sram_we_n && sram_dq_oe && sram_dq_o == $past(req_wdata, 3))
    ##1 (sram_we_n && sram_cs_n && sram_dq_oe))
    else $error("write with enable low drives too early or too late");
  a_read_pins: assert property (req_valid && req_ready && !req_write |=> !sram_cs_n
    && !sram_oe_n && sram_we_n && !sram_dq_oe && sram_addr == $past(req_addr))
    else $error("read pins wrong");
  a_write_seq: assert property (!WR_OE_LOW && req_valid && req_ready && req_write |=>
    (!sram_cs_n && sram_we_n && sram_dq_oe && sram_dq_o == $past(req_wdata))
    ##1 (!sram_we_n && !sram_cs_n) ##1 (sram_we_n && sram_cs_n && sram_dq_oe))
    else $error("write sequence wrong");
  a_addr_stable: assert property ($past(sram_cs_n) == 1'b0 && !sram_cs_n |-> $stable(sram_addr))
    else $error("address moved under select");
  a_we_in_cs: assert property (!sram_we_n |-> !sram_cs_n && $past(sram_cs_n) == 1'b0)
    else $error("strobe without earlier select");
  a_no_bus_fight: assert property (!(sram_dq_oe && !sram_cs_n && !sram_oe_n && sram_we_n))
    else $error("bus contention");
  a_rdata_take: assert property (rsp_valid |-> rsp_rdata == $past(sram_dq_i))
    else $error("read byte not taken from bus");
endmodule : asramc_ctrl_assertions
bind asramc_ctrl asramc_ctrl_assertions #(.WR_OE_LOW(WR_OE_LOW))
  chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
  .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done),
  .sram_addr(sram_addr), .sram_cs_n(sram_cs_n), .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n),
  .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe), .sram_dq_i(sram_dq_i));
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench: random reads and writes through the controller into the memory model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, wr_done;
  logic [16:0] req_addr = 17'h00000, sram_addr;
  logic [7:0] req_wdata = 8'h00, rsp_rdata, sram_dq_o;
  logic sram_cs_n, sram_oe_n, sram_we_n, sram_dq_oe;
  wire logic [7:0] m_dq;
  wire logic [7:0] dq_bus;
  logic req_ready2, rsp_valid2, wr_done2, sram_cs2_n, sram_oe2_n, sram_we2_n, sram_dq_oe2;
  logic [16:0] sram_addr2;
  logic [7:0] rsp_rdata2, sram_dq_o2;
  wire logic [7:0] m_dq2;
  wire logic [7:0] dq_bus2;
  logic [7:0] shadow [int];
  logic [31:0] seed = 32'h14F56AD1;
  int n_errors = 0;
  int n_checks = 0;
  assign dq_bus = sram_dq_oe ? sram_dq_o : m_dq;
  assign dq_bus2 = sram_dq_oe2 ? sram_dq_o2 : m_dq2;
  asramc_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done), .sram_addr(sram_addr),
    .sram_cs_n(sram_cs_n), .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n),
    .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe), .sram_dq_i(dq_bus));
  asramc_mem_model mem_u (.addr(sram_addr), .cs_n(sram_cs_n), .oe_n(sram_oe_n),
    .we_n(sram_we_n), .dq_in(dq_bus), .dq_out(m_dq));
  // Second controller keeps output enable low through writes, on its own memory
  asramc_ctrl #(.FAST_GRADE(1'b0), .WR_OE_LOW(1'b1)) dut_oe_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready2), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid2),
    .rsp_rdata(rsp_rdata2), .wr_done(wr_done2), .sram_addr(sram_addr2),
    .sram_cs_n(sram_cs2_n), .sram_oe_n(sram_oe2_n), .sram_we_n(sram_we2_n),
    .sram_dq_o(sram_dq_o2), .sram_dq_oe(sram_dq_oe2), .sram_dq_i(dq_bus2));
  asramc_mem_model mem2_u (.addr(sram_addr2), .cs_n(sram_cs2_n), .oe_n(sram_oe2_n),
    .we_n(sram_we2_n), .dq_in(dq_bus2), .dq_out(m_dq2));
  initial forever #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] exp_rd(input logic [16:0] a);
    return shadow.exists(int'(a)) ? shadow[int'(a)] : (a[7:0] ^ 8'h5A);
  endfunction : exp_rd
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask : tick
  // Request stays up past the take with other values, so a busy controller must ignore it
  task automatic acc(input logic w, input logic [16:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (!(req_ready === 1'b1 && req_ready2 === 1'b1) && k < 20)
    begin
      tick();
      k++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    tick();
    req_write = ~w;
    req_addr = ~a;
    req_wdata = ~d;
    tick();
    if (w)
    begin
      tick();
      `CHK(wr_done, 1'b1)
      tick();
      `CHK(wr_done2, 1'b1)
      shadow[int'(a)] = d;
    end
    else
    begin
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp_rd(a))
      `CHK(rsp_valid2, 1'b1)
      `CHK(rsp_rdata2, exp_rd(a))
    end
    req_valid = 1'b0;
  endtask : acc
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    acc(1'b0, 17'h1FFFF, 8'h00);
    acc(1'b1, 17'h1FFFF, 8'hC3);
    acc(1'b1, 17'h00000, 8'hFF);
    acc(1'b0, 17'h1FFFF, 8'h00);
    acc(1'b0, 17'h00000, 8'h00);
    for (int i = 0; i < 300; i++)
    begin
      seed = xs(seed);
      acc(seed[31], {seed[16:5] & 12'h00F, seed[4:0]}, seed[24:17]);
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
